// ### lps_consts.svh
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// Register offsets
`define LPS_OFS_LIGHT_GAIN      8'h04
`define LPS_OFS_LIGHT_TIME      8'h05
`define LPS_OFS_EMITTER_CTRL    8'h06
`define LPS_OFS_PROX_GAIN       8'h07
`define LPS_OFS_PROX_PULSE      8'h08
`define LPS_OFS_PROX_TIME       8'h09
`define LPS_OFS_PROX_OFS_LOW    8'h14
`define LPS_OFS_PROX_OFS_HIGH   8'h15
`define LPS_OFS_PROX_COUNT_LOW  8'h18
`define LPS_OFS_PROX_COUNT_HIGH 8'h19
`define LPS_OFS_CH0_LOW         8'h1c
`define LPS_OFS_CH0_HIGH        8'h1d
`define LPS_OFS_CH1_LOW         8'h1e
`define LPS_OFS_CH1_HIGH        8'h1f

// Reset values
`define LPS_RST_LIGHT_GAIN      8'h00
`define LPS_RST_LIGHT_TIME      8'h3f
`define LPS_RST_EMITTER_CTRL    8'h48
`define LPS_RST_PROX_GAIN       8'h00
`define LPS_RST_PROX_PULSE      8'h01
`define LPS_RST_PROX_TIME       8'h0f
`define LPS_RST_PROX_OFS        16'h0000

// Field limits
`define LPS_LIGHT_FULL_TIME     8'h3f
`define LPS_PROX_FULL_TIME      4'hf

// Timing: one measurement step
`define LPS_CLK_PERIOD_NS       20
`define LPS_STEP_TIME_NS        1000
`define LPS_STEP_CYCLES ((`LPS_STEP_TIME_NS + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)

`endif

// ### lps_pkg.sv
package lps_pkg;

  typedef struct packed {
    logic [1:0] current;
    logic [5:0] width;
  } emitter_ctrl_s;

  typedef enum logic [2:0] {
    I_IDLE     = 3'b000,
    I_ADDR     = 3'b001,
    I_ADDR_ACK = 3'b010,
    I_WR       = 3'b011,
    I_WR_ACK   = 3'b100,
    I_RD       = 3'b101,
    I_RD_ACK   = 3'b110
  } i2c_state_e;

  typedef enum logic [1:0] {
    P_IDLE = 2'b00,
    P_ON   = 2'b01,
    P_OFF  = 2'b10,
    P_DONE = 2'b11
  } prox_state_e;

endpackage : lps_pkg

// ### light_channel_accum.sv
`timescale 1ns/10ps
module light_channel_accum (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_end,
  input  wire logic        i_pulse,
  input  wire logic [15:0] i_max,
  output logic      [15:0] o_count
);
  import lps_pkg::*;

  logic [15:0] acc_q;
  logic [15:0] acc_d;
  logic [15:0] count_q;
  logic [15:0] count_d;

  always_comb begin
    acc_d   = acc_q;
    count_d = count_q;
    if (i_pulse && acc_q < i_max) begin
      acc_d = acc_q + 16'h0001;  // [RULE6]
    end
    if (i_end) begin
      count_d = (acc_d > i_max) ? i_max : acc_d;  // [RULE6]
      acc_d   = 16'h0000;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_q   <= 16'h0000;
      count_q <= 16'h0000;
    end else begin
      acc_q   <= acc_d;
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule : light_channel_accum

// ### light_proximity_sensor_readout.sv
`timescale 1ns/10ps
`include "lps_consts.svh"
// How it works
// [RULE1] All settings and counts are reached through the I2C slave port.
// [RULE2] Light integration register sets the light conversion time; larger means longer.
// [RULE3] Light time 0x3f or more gives the full 16-bit range 0 to 65535.
// [RULE4] Light gain drives the amplifier and never changes the measurement time.
// [RULE5] Two light channel counts readable as byte pairs at 0x1c/0x1d and 0x1e/0x1f.
// [RULE6] Light channel counts saturate at their top value instead of wrapping.
// [RULE7] Emitter is pulsed; count is intensity with emission minus without.
// [RULE8] Proximity time sets conversion time; 0x0f gives 12-bit results 0 to 4095. Here it only sets the result cap, not the cycle length.
// [RULE9] Proximity gain selects receive gain and resets to zero.
// [RULE10] Emitter control bits 7:6 set drive current, bits 5:0 pulse width.
// [RULE11] Pulse-count register sets pulses per cycle; more pulses lengthen the cycle.
// [RULE12] The 16-bit offset at 0x14/0x15 is subtracted from the raw proximity result.
// [RULE13] Host should program the offset slightly below the measured background.
// [RULE14] An offset above the raw result gives a count of zero, not a wrap.
module light_proximity_sensor_readout #(
  parameter logic [6:0] I2C_ADDR             = 7'h2a,  // Arbitrary slave address
  parameter int         STEP_CYCLES          = `LPS_STEP_CYCLES,
  parameter int         LIGHT_STEPS_PER_CODE = 1024
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_scl,
  input  wire logic                  i_sda,
  input  wire logic [1:0]            i_light_pulse,
  input  wire logic                  i_prox_pulse,
  output logic                       o_sda_o,
  output logic                       o_sda_oe,
  output logic                       o_emitter_on,
  output lps_pkg::emitter_ctrl_s     o_emitter_cfg,
  output logic      [7:0]            o_light_gain,
  output logic      [7:0]            o_prox_gain
);
  import lps_pkg::*;

  // Pin synchronisers: change accepted once stages 2 and 3 agree
  logic [4:0] pin_raw;
  logic [4:0] sync1_q, sync2_q, sync3_q, filt_q, prev_q;
  logic [4:0] filt_d, rise;
  assign pin_raw = {i_prox_pulse, i_light_pulse, i_sda, i_scl};
  always_comb begin
    filt_d = filt_q;
    for (int i = 0; i < 5; i++) begin
      if (sync2_q[i] == sync3_q[i]) begin
        filt_d[i] = sync3_q[i];
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sync1_q <= 5'h03;
      sync2_q <= 5'h03;
      sync3_q <= 5'h03;
      filt_q  <= 5'h03;
      prev_q  <= 5'h03;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q  <= filt_d;
      prev_q  <= filt_q;
    end
  end
  assign rise = filt_q & ~prev_q;

  logic scl, sda, scl_rise, scl_fall, start_c, stop_c;
  assign scl      = filt_q[0];
  assign sda      = filt_q[1];
  assign scl_rise = scl & ~prev_q[0];
  assign scl_fall = ~scl & prev_q[0];
  assign start_c  = scl & prev_q[0] & ~sda & prev_q[1];
  assign stop_c   = scl & prev_q[0] & sda & ~prev_q[1];

  // Register file
  logic [7:0]    light_gain_q, light_gain_d, light_time_q, light_time_d;
  logic [7:0]    prox_gain_q, prox_gain_d, prox_pulse_q, prox_pulse_d;
  logic [7:0]    prox_time_q, prox_time_d;
  logic [15:0]   prox_ofs_q, prox_ofs_d;
  emitter_ctrl_s emitter_q, emitter_d;
  logic [15:0]   light_cnt [2];
  logic [11:0]   prox_count_q, prox_count_d;

  // I2C slave
  i2c_state_e i2c_q, i2c_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shreg_q, shreg_d, ptr_q, ptr_d, rdata;
  logic       rw_q, rw_d, first_q, first_d, nack_q, nack_d, sda_oe_q, sda_oe_d;
  logic       wr_stb;

  always_comb begin
    unique case (ptr_q)
      `LPS_OFS_LIGHT_GAIN:      rdata = light_gain_q;
      `LPS_OFS_LIGHT_TIME:      rdata = light_time_q;
      `LPS_OFS_EMITTER_CTRL:    rdata = emitter_q;
      `LPS_OFS_PROX_GAIN:       rdata = prox_gain_q;
      `LPS_OFS_PROX_PULSE:      rdata = prox_pulse_q;
      `LPS_OFS_PROX_TIME:       rdata = prox_time_q;
      `LPS_OFS_PROX_OFS_LOW:    rdata = prox_ofs_q[7:0];
      `LPS_OFS_PROX_OFS_HIGH:   rdata = prox_ofs_q[15:8];
      `LPS_OFS_PROX_COUNT_LOW:  rdata = prox_count_q[7:0];
      `LPS_OFS_PROX_COUNT_HIGH: rdata = {4'h0, prox_count_q[11:8]};
      `LPS_OFS_CH0_LOW:         rdata = light_cnt[0][7:0];   // [RULE5]
      `LPS_OFS_CH0_HIGH:        rdata = light_cnt[0][15:8];  // [RULE5]
      `LPS_OFS_CH1_LOW:         rdata = light_cnt[1][7:0];   // [RULE5]
      `LPS_OFS_CH1_HIGH:        rdata = light_cnt[1][15:8];  // [RULE5]
      default:                  rdata = 8'h00;
    endcase
  end

  always_comb begin
    i2c_d    = i2c_q;
    cnt_d    = cnt_q;
    shreg_d  = shreg_q;
    ptr_d    = ptr_q;
    rw_d     = rw_q;
    first_d  = first_q;
    nack_d   = nack_q;
    sda_oe_d = sda_oe_q;
    wr_stb   = 1'b0;
    if (start_c) begin  // [RULE1]
      i2c_d    = I_ADDR;
      cnt_d    = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      i2c_d    = I_IDLE;
      sda_oe_d = 1'b0;
    end else if (scl_rise) begin
      unique case (i2c_q)
        I_ADDR, I_WR: begin
          shreg_d = {shreg_q[6:0], sda};
          cnt_d   = cnt_q + 4'h1;
        end
        I_RD_ACK: nack_d = sda;
        I_IDLE, I_ADDR_ACK, I_WR_ACK, I_RD: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (i2c_q)
        I_IDLE: begin
        end
        I_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (shreg_q[7:1] == I2C_ADDR) begin
              i2c_d    = I_ADDR_ACK;
              rw_d     = shreg_q[0];
              sda_oe_d = 1'b1;
            end else begin
              i2c_d = I_IDLE;
            end
          end
        end
        I_ADDR_ACK, I_RD_ACK: begin
          cnt_d   = 4'h0;
          first_d = 1'b1;
          if (i2c_q == I_RD_ACK && nack_q) begin
            i2c_d    = I_IDLE;
            sda_oe_d = 1'b0;
          end else if (rw_q) begin
            i2c_d    = I_RD;
            shreg_d  = {rdata[6:0], 1'b0};
            sda_oe_d = ~rdata[7];
            ptr_d    = ptr_q + 8'h01;
          end else begin
            i2c_d    = I_WR;
            sda_oe_d = 1'b0;
          end
        end
        I_WR: begin
          if (cnt_q == 4'h8) begin
            i2c_d    = I_WR_ACK;
            sda_oe_d = 1'b1;
            if (first_q) begin
              ptr_d   = shreg_q;
              first_d = 1'b0;
            end else begin
              wr_stb = 1'b1;
              ptr_d  = ptr_q + 8'h01;
            end
          end
        end
        I_WR_ACK: begin
          i2c_d    = I_WR;
          cnt_d    = 4'h0;
          sda_oe_d = 1'b0;
        end
        I_RD: begin
          cnt_d = cnt_q + 4'h1;
          if (cnt_q == 4'h7) begin
            i2c_d    = I_RD_ACK;
            sda_oe_d = 1'b0;
          end else begin
            sda_oe_d = ~shreg_q[7];
            shreg_d  = {shreg_q[6:0], 1'b0};
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      i2c_q    <= I_IDLE;
      cnt_q    <= 4'h0;
      shreg_q  <= 8'h00;
      ptr_q    <= 8'h00;
      rw_q     <= 1'b0;
      first_q  <= 1'b0;
      nack_q   <= 1'b0;
      sda_oe_q <= 1'b0;
      o_sda_o  <= 1'b0;
    end else begin
      i2c_q    <= i2c_d;
      cnt_q    <= cnt_d;
      shreg_q  <= shreg_d;
      ptr_q    <= ptr_d;
      rw_q     <= rw_d;
      first_q  <= first_d;
      nack_q   <= nack_d;
      sda_oe_q <= sda_oe_d;
      o_sda_o  <= 1'b0;
    end
  end
  assign o_sda_oe = sda_oe_q;

  // Register writes; read-only and unmapped offsets ignore writes
  always_comb begin
    light_gain_d = light_gain_q;
    light_time_d = light_time_q;
    emitter_d    = emitter_q;
    prox_gain_d  = prox_gain_q;
    prox_pulse_d = prox_pulse_q;
    prox_time_d  = prox_time_q;
    prox_ofs_d   = prox_ofs_q;
    if (wr_stb) begin
      unique case (ptr_q)
        `LPS_OFS_LIGHT_GAIN:    light_gain_d = shreg_q;  // [RULE4]
        `LPS_OFS_LIGHT_TIME:    light_time_d = shreg_q;  // [RULE2]
        `LPS_OFS_EMITTER_CTRL:  emitter_d    = shreg_q;  // [RULE10]
        `LPS_OFS_PROX_GAIN:     prox_gain_d  = shreg_q;  // [RULE9]
        `LPS_OFS_PROX_PULSE:    prox_pulse_d = shreg_q;  // [RULE11]
        `LPS_OFS_PROX_TIME:     prox_time_d  = shreg_q;  // [RULE8]
        `LPS_OFS_PROX_OFS_LOW:  prox_ofs_d[7:0]  = shreg_q;  // [RULE12]
        `LPS_OFS_PROX_OFS_HIGH: prox_ofs_d[15:8] = shreg_q;  // [RULE12]
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      light_gain_q <= `LPS_RST_LIGHT_GAIN;
      light_time_q <= `LPS_RST_LIGHT_TIME;
      emitter_q    <= `LPS_RST_EMITTER_CTRL;
      prox_gain_q  <= `LPS_RST_PROX_GAIN;  // [RULE9]
      prox_pulse_q <= `LPS_RST_PROX_PULSE;
      prox_time_q  <= `LPS_RST_PROX_TIME;
      prox_ofs_q   <= `LPS_RST_PROX_OFS;
    end else begin
      light_gain_q <= light_gain_d;
      light_time_q <= light_time_d;
      emitter_q    <= emitter_d;
      prox_gain_q  <= prox_gain_d;
      prox_pulse_q <= prox_pulse_d;
      prox_time_q  <= prox_time_d;
      prox_ofs_q   <= prox_ofs_d;
    end
  end
  assign o_light_gain  = light_gain_q;
  assign o_prox_gain   = prox_gain_q;
  assign o_emitter_cfg = emitter_q;  // [RULE10]

  // Step divider
  logic [15:0] div_q, div_d;
  logic        step;
  assign step = (div_q == 16'(STEP_CYCLES - 1));
  always_comb div_d = step ? 16'h0000 : div_q + 16'h0001;

  // Ambient light timing: length depends on time register only
  logic [17:0] light_step_q, light_step_d, light_target;
  logic [15:0] light_max;
  logic        light_end;
  assign light_target = 18'((32'(light_time_q) + 32'd1) * LIGHT_STEPS_PER_CODE - 1);  // [RULE2]
  assign light_max    = (light_time_q >= `LPS_LIGHT_FULL_TIME) ? 16'hffff :
                        {6'(light_time_q + 8'h01), 10'h3ff};  // [RULE3]
  assign light_end    = step && (light_step_q >= light_target);  // [RULE4]
  always_comb begin
    light_step_d = light_step_q;
    if (wr_stb && ptr_q == `LPS_OFS_LIGHT_TIME) begin
      // New time starts a fresh period so the step count never overshoots
      light_step_d = 18'h00000;  // [RULE2]
    end else if (light_end) begin
      light_step_d = 18'h00000;
    end else if (step) begin
      light_step_d = light_step_q + 18'h00001;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_light
    light_channel_accum u_accum (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_end   (light_end),
      .i_pulse (rise[2 + g]),
      .i_max   (light_max),
      .o_count (light_cnt[g])
    );
  end

  // Proximity sequencer: emission window then equal dark window per pulse
  prox_state_e prox_q, prox_d;
  logic [7:0]  pulse_idx_q, pulse_idx_d;
  logic [5:0]  win_q, win_d;
  logic [15:0] on_acc_q, on_acc_d, off_acc_q, off_acc_d;
  logic [11:0] prox_max, raw;
  logic [3:0]  ptime;
  logic        emitter_on_d, win_end;
  assign ptime    = (prox_time_q > 8'h0f) ? `LPS_PROX_FULL_TIME : prox_time_q[3:0];
  assign prox_max = {ptime, 8'hff};  // [RULE8]
  assign raw      = (on_acc_q <= off_acc_q) ? 12'h000 :
                    ((on_acc_q - off_acc_q > {4'h0, prox_max}) ? prox_max :
                     12'(on_acc_q - off_acc_q));  // [RULE7]
  assign win_end  = step && (win_q == emitter_q.width);  // [RULE10]

  always_comb begin
    prox_d       = prox_q;
    pulse_idx_d  = pulse_idx_q;
    win_d        = win_q;
    on_acc_d     = on_acc_q;
    off_acc_d    = off_acc_q;
    prox_count_d = prox_count_q;
    if (step && !win_end) begin
      win_d = win_q + 6'h01;
    end
    unique case (prox_q)
      P_IDLE: begin
        prox_d      = P_ON;
        pulse_idx_d = 8'h00;
        win_d       = 6'h00;
        on_acc_d    = 16'h0000;
        off_acc_d   = 16'h0000;
      end
      P_ON: begin
        if (rise[4] && on_acc_q != 16'hffff) begin
          on_acc_d = on_acc_q + 16'h0001;
        end
        if (win_end) begin
          prox_d = P_OFF;
          win_d  = 6'h00;
        end
      end
      P_OFF: begin
        if (rise[4] && off_acc_q != 16'hffff) begin
          off_acc_d = off_acc_q + 16'h0001;  // [RULE7]
        end
        if (win_end) begin
          win_d = 6'h00;
          if (pulse_idx_q == prox_pulse_q) begin  // [RULE11]
            prox_d = P_DONE;
          end else begin
            pulse_idx_d = pulse_idx_q + 8'h01;
            prox_d      = P_ON;
          end
        end
      end
      P_DONE: begin
        prox_d       = P_IDLE;
        prox_count_d = ({4'h0, raw} > prox_ofs_q) ?
                       12'({4'h0, raw} - prox_ofs_q) : 12'h000;  // [RULE12] [RULE14]
      end
    endcase
    emitter_on_d = (prox_d == P_ON);  // [RULE7]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div_q        <= 16'h0000;
      light_step_q <= 18'h00000;
      prox_q       <= P_IDLE;
      pulse_idx_q  <= 8'h00;
      win_q        <= 6'h00;
      on_acc_q     <= 16'h0000;
      off_acc_q    <= 16'h0000;
      prox_count_q <= 12'h000;
      o_emitter_on <= 1'b0;
    end else begin
      div_q        <= div_d;
      light_step_q <= light_step_d;
      prox_q       <= prox_d;
      pulse_idx_q  <= pulse_idx_d;
      win_q        <= win_d;
      on_acc_q     <= on_acc_d;
      off_acc_q    <= off_acc_d;
      prox_count_q <= prox_count_d;
      o_emitter_on <= emitter_on_d;
    end
  end

  // Checks
  logic [8:0] emit_cnt_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      emit_cnt_q <= 9'h000;
    end else if (prox_q == P_IDLE) begin
      emit_cnt_q <= 9'h000;
    end else if (prox_q == P_OFF && win_end) begin
      emit_cnt_q <= emit_cnt_q + 9'h001;
    end
  end

  // Cycles the emitter has been on in the current pulse
  logic [15:0] on_len_q;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      on_len_q <= 16'h0000;
    end else if (o_emitter_on) begin
      on_len_q <= on_len_q + 16'h0001;
    end else begin
      on_len_q <= 16'h0000;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  property p_light_len;
    light_end |-> light_step_q == light_target;
  endproperty
  a_light_len: assert property (p_light_len) else $error("light period wrong"); // [RULE2]
  property p_light_full;
    light_time_q >= 8'h3f |-> light_max == 16'hffff;
  endproperty
  a_light_full: assert property (p_light_full) else $error("light range not full"); // [RULE3]
  property p_gain_time;
    $changed(light_gain_q) && $stable(light_time_q) |-> $stable(light_target);
  endproperty
  a_gain_time: assert property (p_gain_time) else $error("gain changed period"); // [RULE4]
  property p_ch_read;
    i2c_q == I_RD && ptr_q == 8'h1d |-> rdata == light_cnt[0][15:8];
  endproperty
  a_ch_read: assert property (p_ch_read) else $error("channel byte wrong"); // [RULE5]
  property p_light_sat;
    light_end |=> light_cnt[0] <= $past(light_max) && light_cnt[1] <= $past(light_max);
  endproperty
  a_light_sat: assert property (p_light_sat) else $error("light count wrapped"); // [RULE6]
  property p_pulsed;
    o_emitter_on |-> on_len_q < 16'(64 * STEP_CYCLES);
  endproperty
  a_pulsed: assert property (p_pulsed) else $error("emitter stuck on"); // [RULE7]
  property p_prox_full;
    prox_time_q == 8'h0f |-> prox_max == 12'hfff;
  endproperty
  a_prox_full: assert property (p_prox_full) else $error("prox range wrong"); // [RULE8]
  property p_pulses;
    prox_q == P_DONE |-> emit_cnt_q == {1'b0, prox_pulse_q} + 9'h001;
  endproperty
  a_pulses: assert property (p_pulses) else $error("pulse count wrong"); // [RULE11]
  property p_offset;
    prox_q == P_DONE && {4'h0, raw} >= prox_ofs_q |=>
      {4'h0, prox_count_q} + prox_ofs_q == {4'h0, $past(raw)};
  endproperty
  a_offset: assert property (p_offset) else $error("offset not subtracted"); // [RULE12]
  property p_clamp;
    prox_q == P_DONE && {4'h0, raw} < prox_ofs_q |=> prox_count_q == 12'h000;
  endproperty
  a_clamp: assert property (p_clamp) else $error("prox count wrapped"); // [RULE14]

  c_write: cover property (wr_stb);
  c_read_ack: cover property (i2c_q == I_RD_ACK && scl_fall && !nack_q);
  c_prox_done: cover property (prox_q == P_DONE && prox_count_q != 12'h000);

endmodule : light_proximity_sensor_readout

// ### lps_i2c_host.sv
`timescale 1ns/10ps
module lps_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input  wire logic i_clk,
  input  wire logic i_sda_bus,
  output logic      o_scl,
  output logic      o_sda
);
  int   half      = 10;
  logic nack_seen = 1'b0;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // Pins change just after an edge and then hold for n clocks
  task automatic drive(input logic c, input logic d, input int n);
    o_scl <= c;
    o_sda <= d;
    repeat (n) @(posedge i_clk);
  endtask : drive
  // Serves as repeated start too, since the clock is parked low between bytes
  task automatic start_c;
    drive(o_scl, 1'b1, half);
    drive(1'b1, 1'b1, half);
    drive(1'b1, 1'b0, half);
    drive(1'b0, 1'b0, 1);
  endtask : start_c
  task automatic stop_c;
    drive(1'b0, 1'b0, half);
    drive(1'b1, 1'b0, half);
    drive(1'b1, 1'b1, half);
  endtask : stop_c
  task automatic bit_io(input logic b, output logic r);
    drive(1'b0, b, half);
    drive(1'b1, b, half);
    r = i_sda_bus;
    drive(1'b0, b, 1);
  endtask : bit_io
  task automatic byte_wr(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, ack_n);
  endtask : byte_wr
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : byte_rd
  task automatic probe(input logic [6:0] a, output logic ack_n);
    start_c();
    byte_wr({a, 1'b0}, ack_n);
    stop_c();
  endtask : probe
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    logic a0, a1, a2;
    start_c();
    byte_wr({DEV_ADDR, 1'b0}, a0);
    byte_wr(ptr, a1);
    byte_wr(d, a2);
    stop_c();
    nack_seen = a0 | a1 | a2;
  endtask : wr
  // Two bytes in one transfer, low then high, through the auto-incremented pointer
  task automatic rd(input logic [7:0] ptr, output logic [15:0] v);
    logic a0, a1, a2;
    start_c();
    byte_wr({DEV_ADDR, 1'b0}, a0);
    byte_wr(ptr, a1);
    start_c();
    byte_wr({DEV_ADDR, 1'b1}, a2);
    byte_rd(1'b0, v[7:0]);
    byte_rd(1'b1, v[15:8]);
    stop_c();
    nack_seen = a0 | a1 | a2;
  endtask : rd
endmodule : lps_i2c_host

// ### light_proximity_sensor_readout_tb.sv
`timescale 1ns/10ps
`include "lps_consts.svh"
`define CHK(a, e) begin \
  comparisons++; \
  if ((a) !== (e)) begin \
    n_mismatch++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module light_proximity_sensor_readout_tb;
  import lps_pkg::*;
  localparam int STEP = 2;
  localparam logic [7:0] CFG_OFS [8] = '{8'h04, 8'h05, 8'h06, 8'h07,
                                         8'h08, 8'h09, 8'h14, 8'h15};
  // Offset 0x10 sits well below the capped raw level of 0xff
  localparam logic [7:0] CFG_VAL [8] = '{8'h01, 8'h3f, 8'hbf, 8'h01,
                                         8'h0f, 8'h00, 8'h10, 8'h00};
  localparam logic [15:0] RST_VAL [4] = '{{`LPS_RST_LIGHT_TIME, `LPS_RST_LIGHT_GAIN},
                                          {`LPS_RST_PROX_GAIN, `LPS_RST_EMITTER_CTRL},
                                          {`LPS_RST_PROX_TIME, `LPS_RST_PROX_PULSE},
                                          `LPS_RST_PROX_OFS};
  logic          clk         = 1'b0;
  logic          rst         = 1'b1;
  logic [1:0]    light_pulse = 2'b00;
  logic          prox_pulse  = 1'b0;
  logic          light_en    = 1'b0;
  logic          prox_all    = 1'b0;
  logic [1:0]    ph          = 2'd0;
  logic          scl, sda_host, sda_bus, sda_o, sda_oe, emitter_on, ack_n;
  emitter_ctrl_s emitter_cfg;
  logic [7:0]    light_gain, prox_gain;
  logic [15:0]   v;
  int            n_mismatch  = 0;
  int            comparisons = 0;
  int            cycles      = 0;
  int            len;

  assign sda_bus = sda_host & ~(sda_oe & ~sda_o);
  always #10 clk = ~clk;

  lps_i2c_host host (
    .i_clk     (clk),
    .i_sda_bus (sda_bus),
    .o_scl     (scl),
    .o_sda     (sda_host)
  );
  light_proximity_sensor_readout #(
    .STEP_CYCLES          (STEP),
    .LIGHT_STEPS_PER_CODE (4)
  ) dut (
    .i_clk         (clk),
    .i_rst         (rst),
    .i_scl         (scl),
    .i_sda         (sda_bus),
    .i_light_pulse (light_pulse),
    .i_prox_pulse  (prox_pulse),
    .o_sda_o       (sda_o),
    .o_sda_oe      (sda_oe),
    .o_emitter_on  (emitter_on),
    .o_emitter_cfg (emitter_cfg),
    .o_light_gain  (light_gain),
    .o_prox_gain   (prox_gain)
  );

  // Photodiode pulses: three clocks high, three low
  always @(posedge clk) begin
    ph <= (ph == 2'd2) ? 2'd0 : ph + 2'd1;
    if (ph == 2'd2) begin
      light_pulse[0] <= light_en & ~light_pulse[0];
      prox_pulse     <= (emitter_on | prox_all) & ~prox_pulse;
    end
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 95000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic w(input logic [7:0] ofs, input logic [7:0] d);
    host.wr(ofs, d);
    `CHK(host.nack_seen, 1'b0)
  endtask : w
  task automatic r(input logic [7:0] ofs);
    host.rd(ofs, v);
    `CHK(host.nack_seen, 1'b0)
  endtask : r
  task automatic wait_lvl(input logic lvl);
    @(negedge clk);
    len = 1;
    while (emitter_on !== lvl && len < 5000) begin
      @(negedge clk);
      len++;
    end
  endtask : wait_lvl

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK(emitter_cfg, emitter_ctrl_s'(`LPS_RST_EMITTER_CTRL))
    for (int i = 0; i < 4; i++) begin
      r(CFG_OFS[2*i]);
      `CHK(v, RST_VAL[i])
    end
    host.probe(7'h2b, ack_n);
    `CHK(ack_n, 1'b1)
    for (int i = 0; i < 8; i++)
      w(CFG_OFS[i], CFG_VAL[i]);
    for (int i = 0; i < 4; i++) begin
      r(CFG_OFS[2*i]);
      `CHK(v, {CFG_VAL[2*i+1], CFG_VAL[2*i]})
    end
    `CHK(light_gain, 8'h01)
    `CHK(prox_gain, 8'h01)
    `CHK(emitter_cfg.current, 2'b10)
    `CHK(emitter_cfg.width, 6'h3f)
    // Skip any pulse already under way, then time one whole pulse
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    `CHK(len, 64 * STEP)
    // Light on channel 0 only; a 512-clock period holds about 85 pulses
    light_en <= 1'b1;
    repeat (1100) @(posedge clk);
    r(8'h1c);
    `CHK((v >= 16'd84) && (v <= 16'd86), 1'b1)
    w(8'h1e, 8'haa);
    host.half = 30;
    r(8'h1e);
    host.half = 10;
    `CHK(v, 16'h0000)
    w(8'h05, 8'h1f);
    repeat (1100) @(posedge clk);
    r(8'h1c);
    `CHK((v >= 16'd41) && (v <= 16'd44), 1'b1)
    r(8'h30);
    `CHK(v, 16'h0000)
    // 16 pulses of 21 counts each exceed the 255 cap of time 0
    repeat (8300) @(posedge clk);
    r(8'h18);
    `CHK(v, 16'h00ff - 16'h0010)
    w(8'h15, 8'h10);
    repeat (8300) @(posedge clk);
    r(8'h18);
    `CHK(v, 16'h0000)
    // Steady light with and without emission cancels out
    w(8'h15, 8'h00);
    prox_all <= 1'b1;
    repeat (8300) @(posedge clk);
    r(8'h18);
    `CHK(v <= 16'd2, 1'b1)
    final_report();
  end
endmodule : light_proximity_sensor_readout_tb
